/* File: design/tsl_params.svh */
// tsl_params: codes, addresses and reset values of the lock block
// assumes inclusion by bare name from the files that use it
`ifndef TSL_PARAMS_SVH
`define TSL_PARAMS_SVH
// received and transmitted character codes
`define TSL_ESC        8'h1B
`define TSL_LEAD1      8'h5C
`define TSL_STAT_REQ   8'h5E
`define TSL_AMP        8'h26
`define TSL_LC_Q       8'h71
`define TSL_DIG0       8'h30
`define TSL_DIG1       8'h31
`define TSL_UC_L       8'h4C
`define TSL_CR         8'h0D
// status report framing
`define TSL_STAT_HI    4'h3
`define TSL_STAT_LAST  3'h6
// storage word addresses, also the config select codes
`define TSL_NV_STRAP   3'h0
`define TSL_NV_LANG    3'h1
`define TSL_NV_SCOL    3'h2
`define TSL_NV_RET0    3'h3
`define TSL_NV_RET1    3'h4
`define TSL_NV_FLAGS   3'h5
`define TSL_NV_LOCK    3'h6
`define TSL_NV_MARK    3'h7
`define TSL_NVM_MARK   8'hA5
// flag word bit positions
`define TSL_FLG_TWO    0
`define TSL_FLG_RATE   1
// reset values
`define TSL_STRAP_RST  8'h00
`define TSL_LANG_RST   8'h00
`define TSL_SCOL_RST   7'h01
`define TSL_FLAGS_RST  2'h2
`define TSL_LAST_COL   7'h50
// storage and buffer geometry
`define TSL_NV_AW      3
`define TSL_FIFO_W     8
`define TSL_FIFO_D     8
`endif

/* File: design/tsl_pkg.sv */
// tsl_pkg: types shared by the terminal status and lock block
// assumes numbers come from tsl_params.svh
package tsl_pkg;
  typedef logic [7:0] tsl_byte_t;
  // transmit and storage sequencer
  typedef enum logic [3:0] {
    TX_LOAD    = 4'b0000,
    TX_IDLE    = 4'b0001,
    TX_ST_ESC  = 4'b0010,
    TX_ST_LEAD = 4'b0011,
    TX_ST_BYTE = 4'b0100,
    TX_ST_TERM = 4'b0101,
    TX_LN_RD   = 4'b0110,
    TX_LN_WR   = 4'b0111,
    TX_RET0    = 4'b1000,
    TX_RET1    = 4'b1001,
    TX_SAVE    = 4'b1010
  } tsl_tx_st_t;
  // host escape sequence parser
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_ESC  = 3'b001,
    RX_AMP  = 3'b010,
    RX_Q    = 3'b011,
    RX_DIG  = 3'b100
  } tsl_rx_st_t;
endpackage : tsl_pkg

/* File: design/tsl_if.sv */
// tsl_if: byte stream with valid and ready between internal modules
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface tsl_if;
  tsl_pkg::tsl_byte_t data;   // byte offered
  logic               valid;  // byte present
  logic               ready;  // sink takes it
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : tsl_if

/* File: design/tsl_fifo.sv */
// tsl_fifo: small first-in first-out buffer on the transmit path
// assumes a power-of-two depth and one clock
`timescale 1ns/1ps
module tsl_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // filling side
  tsl_if.snk                in_s,
  // draining side
  input  wire logic         out_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];  // storage, no reset needed
  logic [AW-1:0] wr_q;     // write pointer
  logic [AW-1:0] rd_q;     // read pointer
  logic [AW:0]   cnt_q;    // words held
  wire           push = in_s.valid && in_s.ready;
  wire           pop  = out_valid && out_ready;
  // full holds back the sequencer
  assign in_s.ready = cnt_q != (AW+1)'(D);
  assign out_valid  = cnt_q != '0;
  assign out_data   = mem[rd_q];
  // data store
  always_ff @(posedge clk) begin
    if (push) mem[wr_q] <= W'(in_s.data);
  end
  // pointers and count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : tsl_fifo

/* File: design/tsl_nvm.sv */
// tsl_nvm: battery-backed configuration words, registered read
// assumes contents persist across rstn; nothing here is reset
`timescale 1ns/1ps
module tsl_nvm #(
  parameter int AW = 3,
  parameter int W  = 8
) (
  // clock
  input  wire logic          clk,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // read port
  input  wire logic [AW-1:0] raddr,
  output logic [W-1:0]       rdata
);
  logic [W-1:0] mem [2**AW] = '{default: '0}; // blank at power-up
  // one write and one registered read per cycle
  always_ff @(posedge clk) begin
    if (we) mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end
endmodule : tsl_nvm

/* File: design/tsl_top.sv */
// tsl_top: status report, line send, return characters, config lock
// assumes byte links on rx and tx, a line port one cycle behind
// its column, and battery-backed storage
//
// How it works
// - report: lead escape, bytes zero to six, terminator
// - status byte high nibble forced to 0011
// - nibble value maps linearly onto sixteen characters
// - report on self-test or host request
// - line send skips columns left of start
// - return sends one or two chars, default CR
// - refresh rate setting selects 50/60, default 60
// - lock rejects strap and language changes
// - lock sequences honoured only outside config mode
// - leaving config mode saves all settings
`timescale 1ns/1ps
`include "tsl_params.svh"
module tsl_top (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rstn,
  // bytes from the host
  input  wire logic               rx_valid,
  input  wire tsl_pkg::tsl_byte_t rx_data,
  output logic                    rx_ready,
  // bytes to the host
  output logic                    tx_valid,
  output tsl_pkg::tsl_byte_t      tx_data,
  input  wire logic               tx_ready,
  // local events
  input  wire logic               self_test,
  input  wire logic               key_enter,
  input  wire logic               key_return,
  input  wire logic [27:0]        status_nib,
  // display line read port
  output logic [6:0]              line_col,
  input  wire tsl_pkg::tsl_byte_t line_char,
  // configuration mode and writes
  input  wire logic               cfg_mode,
  input  wire logic               cfg_wr,
  input  wire logic [2:0]         cfg_sel,
  input  wire tsl_pkg::tsl_byte_t cfg_wdata,
  output logic                    cfg_reject,
  // configuration state
  output tsl_pkg::tsl_byte_t      strap_cfg,
  output tsl_pkg::tsl_byte_t      lang_cfg,
  output logic [6:0]              start_col,
  output logic                    refresh_rate_select,
  output logic                    cfg_locked
);
  import tsl_pkg::*;

  // character for one status nibble
  function automatic tsl_byte_t stat_char(input logic [3:0] nib);
    stat_char = {`TSL_STAT_HI, nib};
  endfunction : stat_char

  // sequencer and parser state
  tsl_tx_st_t tx_q;         // sequencer state
  tsl_tx_st_t tx_d;         // its next value
  tsl_rx_st_t rx_q;         // parser state
  tsl_rx_st_t rx_d;         // its next value
  logic       dig_q;        // lock digit seen, 1 locks
  // pending work, each set wins over its clear
  logic       st_pend_q;    // report wanted
  logic       ln_pend_q;    // line send wanted
  logic       ln_ret_q;     // line came from return
  logic       save_pend_q;  // storage write wanted
  logic       cfgm_q;       // config mode last cycle
  // counters
  logic [3:0] ld_q;         // restore step
  logic [2:0] sv_q;         // save address
  logic [2:0] idx_q;        // status byte index
  logic [6:0] col_q;        // line column
  logic [27:0] stat_q;      // status snapshot
  // configuration held
  tsl_byte_t  strap_q;
  tsl_byte_t  lang_q;
  logic [6:0] scol_q;
  tsl_byte_t  ret0_q;
  tsl_byte_t  ret1_q;
  logic [1:0] flags_q;      // two chars, rate 60
  logic       lock_q;
  logic       rdy_q;        // rx accepted once restored
  logic       rej_q;        // locked write refused
  // storage port
  tsl_byte_t  nv_rdata;
  tsl_byte_t  nv_wdata;
  // buffer fill side
  tsl_if      push_if ();

  // host byte decode
  wire        rx_take   = rx_valid && rdy_q;
  wire        is_esc    = rx_data == `TSL_ESC;
  wire        stat_req  = rx_take && (rx_q == RX_ESC) &&
                          (rx_data == `TSL_STAT_REQ);
  wire        lock_hit  = rx_take && (rx_q == RX_DIG) &&
                          (rx_data == `TSL_UC_L) && !cfg_mode;
  wire        st_set    = stat_req || self_test;
  wire        cfg_exit  = cfgm_q && !cfg_mode;
  wire        save_set  = cfg_exit || lock_hit;

  // restore from storage after reset
  wire        loading   = tx_q == TX_LOAD;
  wire [3:0]  ld_prev   = ld_q - 4'h1;
  wire        ld_take   = loading && (ld_q != 4'h0) && (ld_q < 4'h8);
  wire        ld_end    = loading && (ld_q == 4'h8);
  wire        ld_bad    = ld_end && (nv_rdata != `TSL_NVM_MARK);

  // config writes: strap and language refused while locked
  wire        sel_prot  = (cfg_sel == `TSL_NV_STRAP) ||
                          (cfg_sel == `TSL_NV_LANG);
  wire        sel_sys   = (cfg_sel == `TSL_NV_LOCK) ||
                          (cfg_sel == `TSL_NV_MARK);
  wire        cfg_req   = cfg_wr && cfg_mode && !loading;
  wire        cfg_rej   = cfg_req && lock_q && sel_prot;
  wire        cfg_hit   = cfg_req && !sel_sys && !cfg_rej;

  // one word write path for restore, lock sequence and config
  wire        w_en      = ld_take || lock_hit || cfg_hit;
  wire [2:0]  w_addr    = ld_take  ? ld_prev[2:0] :
                          lock_hit ? `TSL_NV_LOCK : cfg_sel;
  wire [7:0]  w_data    = ld_take  ? nv_rdata :
                          lock_hit ? {7'h00, dig_q} : cfg_wdata;

  // sequencer decode
  wire        idle      = tx_q == TX_IDLE;
  wire        st_go     = idle && !save_pend_q && st_pend_q;
  wire        ln_go     = idle && !save_pend_q && !st_pend_q && ln_pend_q;
  wire        col_ok    = (scol_q != 7'h00) && (scol_q <= `TSL_LAST_COL);
  wire        push_v    = (tx_q == TX_ST_ESC) || (tx_q == TX_ST_LEAD) ||
                          (tx_q == TX_ST_BYTE) || (tx_q == TX_ST_TERM) ||
                          (tx_q == TX_LN_WR) || (tx_q == TX_RET0) ||
                          (tx_q == TX_RET1);
  wire        push_ok   = push_v && push_if.ready;
  wire [3:0]  cur_nib   = stat_q[{idx_q, 2'b00} +: 4];
  wire        two_ch    = flags_q[`TSL_FLG_TWO];
  wire [2:0]  nv_raddr  = ld_q[2:0];

  // byte offered to the buffer; only one source at a time
  assign push_if.valid = push_v;
  assign push_if.data  =
    (tx_q == TX_ST_ESC)  ? `TSL_ESC :
    (tx_q == TX_ST_LEAD) ? `TSL_LEAD1 :
    (tx_q == TX_ST_BYTE) ? stat_char(cur_nib) :
    (tx_q == TX_ST_TERM) ? `TSL_CR :
    (tx_q == TX_LN_WR)   ? line_char :
    (tx_q == TX_RET0)    ? ret0_q : ret1_q;

  // word saved at each address
  assign nv_wdata =
    (sv_q == `TSL_NV_STRAP) ? strap_q :
    (sv_q == `TSL_NV_LANG)  ? lang_q :
    (sv_q == `TSL_NV_SCOL)  ? {1'b0, scol_q} :
    (sv_q == `TSL_NV_RET0)  ? ret0_q :
    (sv_q == `TSL_NV_RET1)  ? ret1_q :
    (sv_q == `TSL_NV_FLAGS) ? {6'h00, flags_q} :
    (sv_q == `TSL_NV_LOCK)  ? {7'h00, lock_q} : `TSL_NVM_MARK;

  // parser: a fresh escape always restarts the match
  always_comb begin
    rx_d = RX_IDLE;
    if (is_esc) begin
      rx_d = RX_ESC;
    end else begin
      case (rx_q)
        RX_ESC:  rx_d = (rx_data == `TSL_AMP) ? RX_AMP : RX_IDLE;
        RX_AMP:  rx_d = (rx_data == `TSL_LC_Q) ? RX_Q : RX_IDLE;
        RX_Q: begin
          if ((rx_data == `TSL_DIG0) || (rx_data == `TSL_DIG1)) begin
            rx_d = RX_DIG;
          end
        end
        default: rx_d = RX_IDLE;
      endcase
    end
  end

  // parser state and digit
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_q  <= RX_IDLE;
      dig_q <= 1'b0;
    end else if (rx_take) begin
      rx_q <= rx_d;
      if (rx_q == RX_Q) dig_q <= rx_data == `TSL_DIG1;
    end
  end

  // sequencer: a report runs whole before anything else is started
  always_comb begin
    tx_d = tx_q;
    case (tx_q)
      TX_LOAD: if (ld_end) tx_d = TX_IDLE;
      TX_IDLE: begin
        if (save_pend_q) begin
          tx_d = TX_SAVE;
        end else if (st_pend_q) begin
          tx_d = TX_ST_ESC;
        end else if (ln_pend_q) begin
          tx_d = col_ok ? TX_LN_RD : (ln_ret_q ? TX_RET0 : TX_IDLE);
        end
      end
      TX_ST_ESC:  if (push_ok) tx_d = TX_ST_LEAD;
      TX_ST_LEAD: if (push_ok) tx_d = TX_ST_BYTE;
      TX_ST_BYTE: begin
        if (push_ok && (idx_q == `TSL_STAT_LAST)) tx_d = TX_ST_TERM;
      end
      TX_ST_TERM: if (push_ok) tx_d = TX_IDLE;
      TX_LN_RD:   tx_d = TX_LN_WR;
      TX_LN_WR: begin
        if (push_ok && (col_q == `TSL_LAST_COL)) begin
          tx_d = ln_ret_q ? TX_RET0 : TX_IDLE;
        end else if (push_ok) begin
          tx_d = TX_LN_RD;
        end
      end
      TX_RET0: if (push_ok) tx_d = two_ch ? TX_RET1 : TX_IDLE;
      TX_RET1: if (push_ok) tx_d = TX_IDLE;
      TX_SAVE: if (sv_q == `TSL_NV_MARK) tx_d = TX_IDLE;
      default: tx_d = TX_IDLE;
    endcase
  end

  // sequencer state
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) tx_q <= TX_LOAD;
    else tx_q <= tx_d;
  end

  // restore and save counters
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ld_q <= 4'h0;
      sv_q <= 3'h0;
    end else begin
      if (loading) ld_q <= ld_q + 4'h1;
      if (tx_q == TX_SAVE) sv_q <= sv_q + 3'h1;
      else sv_q <= 3'h0;
    end
  end

  // pending flags: the set term wins over the clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_pend_q   <= 1'b0;
      ln_pend_q   <= 1'b0;
      ln_ret_q    <= 1'b0;
      save_pend_q <= 1'b0;
      cfgm_q      <= 1'b0;
    end else begin
      st_pend_q   <= (st_pend_q && !st_go) || st_set;
      ln_pend_q   <= (ln_pend_q && !ln_go) || key_enter || key_return;
      save_pend_q <= (save_pend_q && !(idle && save_pend_q)) || save_set;
      cfgm_q      <= cfg_mode;
      if (key_enter || key_return) ln_ret_q <= key_return;
    end
  end

  // report snapshot keeps all seven bytes from one instant
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stat_q <= 28'h0000000;
      idx_q  <= 3'h0;
    end else if (st_go) begin
      stat_q <= status_nib;
      idx_q  <= 3'h0;
    end else if (push_ok && (tx_q == TX_ST_BYTE)) begin
      idx_q  <= idx_q + 3'h1;
    end
  end

  // line column walks from the start column to the end of line
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) col_q <= `TSL_SCOL_RST;
    else if (ln_go) col_q <= scol_q;
    else if (push_ok && (tx_q == TX_LN_WR)) col_q <= col_q + 7'h01;
  end

  // configuration; a blank store falls back to defaults
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strap_q <= `TSL_STRAP_RST;
      lang_q  <= `TSL_LANG_RST;
      scol_q  <= `TSL_SCOL_RST;
      ret0_q  <= `TSL_CR;
      ret1_q  <= `TSL_CR;
      flags_q <= `TSL_FLAGS_RST;
      lock_q  <= 1'b0;
    end else if (ld_bad) begin
      strap_q <= `TSL_STRAP_RST;
      lang_q  <= `TSL_LANG_RST;
      scol_q  <= `TSL_SCOL_RST;
      ret0_q  <= `TSL_CR;
      ret1_q  <= `TSL_CR;
      flags_q <= `TSL_FLAGS_RST;
      lock_q  <= 1'b0;
    end else if (w_en) begin
      case (w_addr)
        `TSL_NV_STRAP: strap_q <= w_data;
        `TSL_NV_LANG:  lang_q  <= w_data;
        `TSL_NV_SCOL:  scol_q  <= w_data[6:0];
        `TSL_NV_RET0:  ret0_q  <= w_data;
        `TSL_NV_RET1:  ret1_q  <= w_data;
        `TSL_NV_FLAGS: flags_q <= w_data[1:0];
        `TSL_NV_LOCK:  lock_q  <= w_data[0];
        default:       lock_q  <= lock_q;
      endcase
    end
  end

  // status outputs, all registered
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdy_q <= 1'b0;
      rej_q <= 1'b0;
    end else begin
      rdy_q <= !loading || ld_end;
      rej_q <= cfg_rej;
    end
  end

  assign rx_ready            = rdy_q;
  assign cfg_reject          = rej_q;
  assign line_col            = col_q;
  assign strap_cfg           = strap_q;
  assign lang_cfg            = lang_q;
  assign start_col           = scol_q;
  assign refresh_rate_select = flags_q[`TSL_FLG_RATE];
  assign cfg_locked          = lock_q;

  // storage: read during restore, written during save
  tsl_nvm #(
    .AW (`TSL_NV_AW),
    .W  (8)
  ) u_nvm (
    .clk   (ref_clk),
    .we    (tx_q == TX_SAVE),
    .waddr (sv_q),
    .wdata (nv_wdata),
    .raddr (nv_raddr),
    .rdata (nv_rdata)
  );

  // transmit buffer; a stalled uart backs up into the sequencer
  tsl_fifo #(
    .W (`TSL_FIFO_W),
    .D (`TSL_FIFO_D)
  ) u_fifo (
    .clk       (ref_clk),
    .rstn      (rstn),
    .in_s      (push_if.snk),
    .out_ready (tx_ready),
    .out_valid (tx_valid),
    .out_data  (tx_data)
  );
endmodule : tsl_top

/* File: tb/tsl_top_assertions.sv */
// tsl_top_assertions: port checks for the status and lock block
// assumes it is bound into tsl_top by the statement at the foot
`timescale 1ns/1ps
`include "tsl_params.svh"
module tsl_top_assertions (
  // clock and reset
  input wire logic               ref_clk,
  input wire logic               rstn,
  // host link
  input wire logic               rx_valid,
  input wire tsl_pkg::tsl_byte_t rx_data,
  input wire logic               rx_ready,
  input wire logic               tx_valid,
  input wire tsl_pkg::tsl_byte_t tx_data,
  input wire logic               tx_ready,
  // configuration
  input wire logic               cfg_mode,
  input wire logic               cfg_wr,
  input wire logic [2:0]         cfg_sel,
  input wire tsl_pkg::tsl_byte_t cfg_wdata,
  input wire logic               cfg_reject,
  input wire logic [6:0]         start_col,
  input wire logic               cfg_locked
);
  import tsl_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic       pop;   // byte leaves for the host
  logic       take;  // host byte accepted
  logic       wr_ok; // config-mode write once restored
  logic       lk_wr; // strap or language write while locked
  logic [3:0] rep_q; // slot inside a status report, 0 outside
  logic [3:0] rep_d;
  assign pop   = tx_valid && tx_ready;
  assign take  = rx_valid && rx_ready;
  assign wr_ok = cfg_wr && cfg_mode && rx_ready;
  assign lk_wr = wr_ok && cfg_locked && cfg_sel <= `TSL_NV_LANG;
  // report slot, counted from the lead pair
  assign rep_d = (rep_q == 4'h0) ? {3'h0, tx_data == `TSL_ESC}
               : (rep_q == 4'h1) ? ((tx_data == `TSL_LEAD1) ? 4'h2 : 4'h0)
               : (rep_q == 4'h9) ? 4'h0 : rep_q + 4'h1;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) rep_q <= 4'h0;
    else if (pop) rep_q <= rep_d;
  end
  sequence s_by(tsl_byte_t b);
    take && rx_data == b;
  endsequence
  // lock and unlock differ only in the digit
  sequence s_lk(tsl_byte_t d);
    s_by(`TSL_ESC) ##1 s_by(`TSL_AMP) ##1 s_by(`TSL_LC_Q)
      ##1 s_by(d) ##1 s_by(`TSL_UC_L) ##0 !cfg_mode;
  endsequence
  property p_scol;
    wr_ok && cfg_sel == `TSL_NV_SCOL
      |=> start_col == $past(cfg_wdata[6:0]);
  endproperty
  property p_rej;
    lk_wr |=> cfg_reject;
  endproperty
  property p_rej_src;
    cfg_reject |-> $past(lk_wr);
  endproperty
  property p_lock;
    s_lk(`TSL_DIG1) |=> cfg_locked;
  endproperty
  property p_unlock;
    s_lk(`TSL_DIG0) |=> !cfg_locked;
  endproperty
  property p_hi;
    pop && rep_q inside {[4'h2:4'h8]} |-> tx_data[7:4] == 4'h3;
  endproperty
  property p_term;
    pop && rep_q == 4'h9 |-> tx_data == `TSL_CR;
  endproperty
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_scol: assert property (p_scol) else $error("start col not taken");
  a_rej: assert property (p_rej) else $error("locked write not refused");
  a_rej_src: assert property (p_rej_src) else $error("stray refusal");
  a_lock: assert property (p_lock) else $error("lock not set");
  a_unlock: assert property (p_unlock) else $error("lock not clear");
  a_hi: assert property (p_hi) else $error("status high nibble");
  a_term: assert property (p_term) else $error("report end");
  a_hold: assert property (p_hold) else $error("tx byte moved");
endmodule : tsl_top_assertions
bind tsl_top tsl_top_assertions i_tsl_top_assertions (
  .ref_clk(ref_clk), .rstn(rstn), .rx_valid(rx_valid),
  .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_ready(tx_ready), .cfg_mode(cfg_mode),
  .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_wdata(cfg_wdata),
  .cfg_reject(cfg_reject), .start_col(start_col),
  .cfg_locked(cfg_locked));

/* File: tb/tsl_host_model.sv */
// tsl_host_model: host computer at the far end of the byte link
// assumes the bench calls send and reads got; one shared clock
`timescale 1ns/1ps
module tsl_host_model (
  // clock and pacing
  input  wire logic               ref_clk,
  input  wire logic               stall,
  // bytes to the block
  output tsl_pkg::tsl_byte_t      rx_data,
  output logic                    rx_valid,
  input  wire logic               rx_ready,
  // bytes from the block
  input  wire logic               tx_valid,
  input  wire tsl_pkg::tsl_byte_t tx_data,
  output logic                    tx_ready
);
  import tsl_pkg::*;
  tsl_byte_t  got[$];      // bytes received, oldest first
  logic [1:0] ph_q = 2'h0; // one slot in four when stalled
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b1;
  end
  // readiness moves off the sampling edge
  always @(negedge ref_clk) begin
    ph_q     <= ph_q + 2'h1;
    tx_ready <= !stall || ph_q == 2'h3;
  end
  always @(posedge ref_clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
  // bytes go back to back, each held until taken
  task automatic send(input tsl_byte_t s[$]);
    foreach (s[i]) begin
      @(negedge ref_clk);
      rx_valid = 1'b1;
      rx_data  = s[i];
      @(posedge ref_clk);
      while (rx_ready !== 1'b1) @(posedge ref_clk);
    end
    @(negedge ref_clk);
    rx_valid = 1'b0;
    rx_data  = ~rx_data; // no stale byte
  endtask : send
endmodule : tsl_host_model

/* File: tb/tb_tsl_top.sv */
// tb_tsl_top: self-checking bench for the status and lock block
// assumes the host model and the bound checker compile beside it
`timescale 1ns/1ps
`include "tsl_params.svh"
module tb_tsl_top;
  import tsl_pkg::*;
  typedef struct {logic [2:0] sel; tsl_byte_t wd; tsl_byte_t ex;} tsl_row_t;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        stall = 1'b0;
  logic        rx_valid, rx_ready, tx_valid, tx_ready, rej;
  tsl_byte_t   rx_data, tx_data, line_char, cfg_wdata, strap_cfg, lang_cfg;
  logic        self_test, key_enter, key_return, cfg_mode, cfg_wr;
  logic [27:0] status_nib;
  logic [6:0]  line_col, start_col;
  logic [2:0]  cfg_sel;
  logic        cfg_reject, refresh_rate_select, cfg_locked;
  int          errors = 0, cmp_count = 0, cyc = 0;
  tsl_byte_t   e[$];
  // rows: select, data, value seen on the output
  tsl_row_t rows[5] = '{'{3'h0, 8'h5A, 8'h5A}, '{3'h1, 8'h03, 8'h03},
    '{3'h2, 8'h4E, 8'h4E}, '{3'h5, 8'h00, 8'h00}, '{3'h5, 8'h03, 8'h01}};
  tsl_top i_tsl_top (.ref_clk(ref_clk), .rstn(rstn), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .self_test(self_test),
    .key_enter(key_enter), .key_return(key_return),
    .status_nib(status_nib), .line_col(line_col), .line_char(line_char),
    .cfg_mode(cfg_mode), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
    .cfg_wdata(cfg_wdata), .cfg_reject(cfg_reject), .strap_cfg(strap_cfg),
    .lang_cfg(lang_cfg), .start_col(start_col),
    .refresh_rate_select(refresh_rate_select), .cfg_locked(cfg_locked));
  tsl_host_model i_tsl_host_model (.ref_clk(ref_clk), .stall(stall),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  always #2 ref_clk = ~ref_clk;
  // display text: column c holds 0x40 plus c
  always @(negedge ref_clk) line_char <= 8'h40 + {1'b0, line_col};
  // hang guard, far above the run's length
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("[ERR] %0t run too long", $time);
      close_out();
    end
  end
  task automatic chk_val(input tsl_byte_t g, input tsl_byte_t x);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, g, x);
    end
  endtask : chk_val
  task automatic chk_bit(input logic g, input logic x);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("[ERR] %0t flag %b want %b", $time, g, x);
    end
  endtask : chk_bit
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // three cycles of reset, then the restore
  task automatic do_reset();
    int k;
    k = 0;
    rstn = 1'b0;
    repeat (3) @(negedge ref_clk);
    rstn = 1'b1;
    while (rx_ready !== 1'b1 && k < 50) begin
      @(negedge ref_clk);
      k++;
    end
    repeat (2) @(negedge ref_clk);
  endtask : do_reset
  task automatic cfg_write(input logic [2:0] s, input tsl_byte_t d);
    @(negedge ref_clk);
    cfg_wr = 1'b1;
    cfg_sel = s;
    cfg_wdata = d;
    @(negedge ref_clk);
    cfg_wr = 1'b0;
    rej = cfg_reject;
  endtask : cfg_write
  // pulse: 0 self test, 1 enter, 2 return
  task automatic pulse(input int w);
    @(negedge ref_clk);
    self_test = (w == 0);
    key_enter = (w == 1);
    key_return = (w == 2);
    @(negedge ref_clk);
    {self_test, key_enter, key_return} = 3'h0;
  endtask : pulse
  // wait for the stream, compare count and bytes
  task automatic expect_q();
    int k;
    k = 0;
    while (i_tsl_host_model.got.size() < e.size() && k < 2000) begin
      @(negedge ref_clk);
      k++;
    end
    chk_val(8'(i_tsl_host_model.got.size()), 8'(e.size()));
    foreach (e[i]) chk_val(i_tsl_host_model.got.pop_front(), e[i]);
  endtask : expect_q
  task automatic chk_report(input logic [27:0] n);
    e = {`TSL_ESC, `TSL_LEAD1};
    for (int k = 0; k < 7; k++) e.push_back({4'h3, n[4*k +: 4]});
    e.push_back(`TSL_CR);
    expect_q();
  endtask : chk_report
  task automatic lock_seq(input tsl_byte_t d);
    e = {`TSL_ESC, `TSL_AMP, `TSL_LC_Q, d, `TSL_UC_L};
    i_tsl_host_model.send(e);
    repeat (12) @(negedge ref_clk);
  endtask : lock_seq
  initial begin
    {self_test, key_enter, key_return, cfg_mode, cfg_wr} = 5'h00;
    cfg_sel = 3'h0;
    cfg_wdata = 8'h00;
    line_char = 8'h00;
    status_nib = 28'h5A3C1F0;
    do_reset();
    chk_val(strap_cfg, 8'h00);
    chk_val(lang_cfg, 8'h00);
    chk_val({1'b0, start_col}, 8'h01);
    chk_bit(refresh_rate_select, 1'b1);
    // default return, whole line, slow host
    stall = 1'b1;
    e = {};
    for (int c = 1; c <= 80; c++) e.push_back(8'h40 + 8'(c));
    e.push_back(`TSL_CR);
    pulse(2);
    expect_q();
    $display("test defaults done");
    cfg_mode = 1'b1;
    foreach (rows[i]) begin
      cfg_write(rows[i].sel, rows[i].wd);
      case (rows[i].sel)
        3'h0: chk_val(strap_cfg, rows[i].ex);
        3'h1: chk_val(lang_cfg, rows[i].ex);
        3'h2: chk_val({1'b0, start_col}, rows[i].ex);
        default: chk_val({7'h00, refresh_rate_select}, rows[i].ex);
      endcase
    end
    cfg_write(3'h3, 8'h0A);
    cfg_write(3'h4, `TSL_CR);
    cfg_mode = 1'b0;
    $display("test table done");
    pulse(1);
    e = {8'h8E, 8'h8F, 8'h90};
    expect_q();
    pulse(2);
    e = {8'h8E, 8'h8F, 8'h90, 8'h0A, `TSL_CR};
    expect_q();
    $display("test line done");
    pulse(0);
    chk_report(status_nib);
    status_nib = 28'h9876E2D;
    e = {`TSL_ESC, `TSL_STAT_REQ};
    i_tsl_host_model.send(e);
    chk_report(status_nib);
    $display("test report done");
    cfg_mode = 1'b1;
    lock_seq(`TSL_DIG1);
    chk_bit(cfg_locked, 1'b0);
    cfg_mode = 1'b0;
    repeat (12) @(negedge ref_clk);
    lock_seq(`TSL_DIG1);
    chk_bit(cfg_locked, 1'b1);
    cfg_mode = 1'b1;
    cfg_write(3'h0, 8'h11);
    chk_bit(rej, 1'b1);
    chk_val(strap_cfg, 8'h5A);
    cfg_write(3'h1, 8'h22);
    chk_bit(rej, 1'b1);
    cfg_write(3'h2, 8'h02);
    chk_bit(rej, 1'b0);
    cfg_mode = 1'b0;
    repeat (12) @(negedge ref_clk);
    do_reset();
    chk_bit(cfg_locked, 1'b1);
    chk_val({1'b0, start_col}, 8'h02);
    chk_val(lang_cfg, 8'h03);
    lock_seq(`TSL_DIG0);
    chk_bit(cfg_locked, 1'b0);
    cfg_mode = 1'b1;
    cfg_write(3'h0, 8'h11);
    chk_val(strap_cfg, 8'h11);
    $display("test lock done");
    close_out();
  end
endmodule : tb_tsl_top
